// File: pkg/tpd_map.vh
// tpd_map.vh: address map, field positions, masks and timing counts
// of the transceiver pll divider configuration block.
// assumes a 125 MHz reconfiguration clock and 16-bit reconfig words.
`ifndef TPD_MAP_VH
`define TPD_MAP_VH

// reconfiguration port widths
`define TPD_DRP_AW          9
`define TPD_DRP_DW          16
`define TPD_NUM_WORDS       8

// word addresses
`define TPD_ADDR_QCFG_LO    9'h032
`define TPD_ADDR_QCFG_HI    9'h033
`define TPD_ADDR_QFBDIV     9'h036
`define TPD_ADDR_QRATIO     9'h037
`define TPD_ADDR_CCFG_LO    9'h05c
`define TPD_ADDR_CCFG_HI    9'h05d
`define TPD_ADDR_CDIV       9'h05e
`define TPD_ADDR_OUTDIV     9'h088

// writable bits per word; all other bits read zero
`define TPD_MASK_QCFG_LO    16'hffff
`define TPD_MASK_QCFG_HI    16'hffff
`define TPD_MASK_QFBDIV     16'h03ff
`define TPD_MASK_QRATIO     16'h0040
`define TPD_MASK_CCFG_LO    16'hff00
`define TPD_MASK_CCFG_HI    16'hffff
`define TPD_MASK_CDIV       16'h1fff
`define TPD_MASK_OUTDIV     16'h0007

// reset value of every word
`define TPD_WORD_RST        16'h0000

// field positions
`define TPD_BAND_BIT        6
`define TPD_QREF_MSB        15
`define TPD_QREF_LSB        11
`define TPD_QFB_MSB         9
`define TPD_QFB_LSB         0
`define TPD_QRATIO_BIT      6
`define TPD_CREF_MSB        12
`define TPD_CREF_LSB        8
`define TPD_CPRE_BIT        7
`define TPD_CFB_MSB         6
`define TPD_CFB_LSB         0
`define TPD_RXOUT_MSB       2
`define TPD_RXOUT_LSB       0

// special feedback value that needs ratio select low
`define TPD_QFB_NO_RATIO    10'h042

// serial bits per core clock cycle
`define TPD_CORE_RATIO      12'h028

// reset sequencer hold time
`define TPD_CLK_MHZ         125
`define TPD_RST_HOLD_NS     1000
`define TPD_RST_HOLD_CYC    ((`TPD_RST_HOLD_NS * `TPD_CLK_MHZ + 999) / 1000)

`endif

// File: hdl/tpd_reset_seq.v
// tpd_reset_seq.v: reset state machine run from the reconfig clock.
// assumes restart comes from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module tpd_reset_seq #(
	parameter integer CYCLES = 125,
	parameter integer CNT_W  = 16
) (
	// clock and reset
	input  wire ref_clk,
	input  wire reset_n,
	// control
	input  wire restart,
	output reg  done_q
);

	localparam ST_HOLD = 1'b0;
	localparam ST_DONE = 1'b1;

	reg             state_q;
	reg             state_d;
	reg [CNT_W-1:0] cnt_q;
	reg [CNT_W-1:0] cnt_d;
	reg             done_d;

	always @*
	begin
		state_d = state_q;
		cnt_d   = cnt_q;
		done_d  = done_q;
		case (state_q)
			ST_HOLD:
			begin
				if (cnt_q == CYCLES[CNT_W-1:0] - 1'b1)
				begin
					state_d = ST_DONE;
					done_d  = 1'b1;
				end
				else
					cnt_d = cnt_q + 1'b1;
			end
			ST_DONE:
			begin
				if (restart)
				begin
					state_d = ST_HOLD;
					cnt_d   = {CNT_W{1'b0}};
					done_d  = 1'b0;
				end
			end
			default:
			begin
				state_d = ST_HOLD;
				cnt_d   = {CNT_W{1'b0}};
				done_d  = 1'b0;
			end
		endcase
	end

	always @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_q <= ST_HOLD;
			cnt_q   <= {CNT_W{1'b0}};
			done_q  <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			done_q  <= done_d;
		end
	end

endmodule // tpd_reset_seq

`default_nettype wire

// File: hdl/tpd_config.v
// tpd_config.v: divider configuration words of the quad and channel
// plls behind the dynamic reconfiguration port, with field decode.
// assumes the port master runs on ref_clk and issues one access at a
// time, waiting for drp_rdy before the next.
//
// Overview of operation
// - Bit 6 of word 0x032 picks the quad pll band, 0 upper and 1 lower.
// - Line rate is twice the pll output over the output divide factor.
// - Quad reference field 15:11 of 0x033 maps 1,2,3,4 to 16,0,1,2.
// - Word 0x05e holds channel reference, prescale and feedback codes.
// - Receive output field 2:0 of 0x088 maps 1,2,4,8,16 to 0..4.
// - Common pll words are reachable only with management and a quad pll.
// - With management and a quad pll both reference clocks are enabled.
// - As a sub-unit the management interface is absent.
// - Management without shared logic drops the common words.
// - Management with debug trims debug ports already in registers.
// - Debug without management gives the full debug port list.
// - The reconfig clock also runs the reset state machine.
// - The core runs 40 bits wide, at one fortieth of the line rate.
`timescale 1ns/1ps
`default_nettype none
`include "tpd_map.vh"

module tpd_config #(
	parameter integer AXI_MGMT_EN  = 1,
	parameter integer SHARED_LOGIC = 1,
	parameter integer XCVR_DEBUG   = 0,
	parameter integer SUB_CORE     = 0,
	parameter integer TX_QUAD_SEL  = 0,
	parameter integer RX_QUAD_SEL  = 0,
	parameter integer RST_CYCLES   = `TPD_RST_HOLD_CYC
) (
	// clock and reset
	input  wire                   ref_clk,
	input  wire                   reset_n,
	// reconfiguration port
	input  wire [`TPD_DRP_AW-1:0] drp_addr,
	input  wire [`TPD_DRP_DW-1:0] drp_di,
	input  wire                   drp_en,
	input  wire                   drp_we,
	output reg  [`TPD_DRP_DW-1:0] drp_do,
	output reg                    drp_rdy,
	// reset sequencing
	input  wire                   seq_restart,
	output wire                   reset_done_q,
	// decoded quad pll settings
	output reg                    quad_band_lower_q,
	output reg  [2:0]             quad_ref_div_q,
	output reg  [9:0]             quad_fb_div_q,
	output reg                    quad_ratio_sel_q,
	// decoded channel pll settings
	output reg  [1:0]             chan_ref_div_q,
	output reg  [2:0]             chan_prescale_q,
	output reg  [2:0]             chan_fb_div_q,
	// receive path
	output reg  [4:0]             rx_out_div_q,
	output reg  [9:0]             rx_line_num_q,
	output reg  [7:0]             rx_line_den_q,
	output reg  [11:0]            rx_core_den_q,
	// configuration status
	output reg  [5:0]             cfg_error_q,
	output reg                    quad_refclk_en_q,
	output reg                    chan_refclk_en_q,
	output reg                    debug_full_q,
	output reg                    debug_trim_q,
	output reg                    common_present_q
);

	localparam MGMT_ON   = (AXI_MGMT_EN != 0) && (SUB_CORE == 0);
	localparam QUAD_USED = (TX_QUAD_SEL != 0) || (RX_QUAD_SEL != 0);
	localparam COMMON_ON = MGMT_ON && (SHARED_LOGIC != 0)
		&& QUAD_USED;
	localparam NW        = `TPD_NUM_WORDS;

	function [`TPD_DRP_AW-1:0] word_addr;
		input integer i;
		begin
			case (i)
				0: word_addr = `TPD_ADDR_QCFG_LO;
				1: word_addr = `TPD_ADDR_QCFG_HI;
				2: word_addr = `TPD_ADDR_QFBDIV;
				3: word_addr = `TPD_ADDR_QRATIO;
				4: word_addr = `TPD_ADDR_CCFG_LO;
				5: word_addr = `TPD_ADDR_CCFG_HI;
				6: word_addr = `TPD_ADDR_CDIV;
				default: word_addr = `TPD_ADDR_OUTDIV;
			endcase
		end
	endfunction

	function [`TPD_DRP_DW-1:0] word_mask;
		input integer i;
		begin
			case (i)
				0: word_mask = `TPD_MASK_QCFG_LO;
				1: word_mask = `TPD_MASK_QCFG_HI;
				2: word_mask = `TPD_MASK_QFBDIV;
				3: word_mask = `TPD_MASK_QRATIO;
				4: word_mask = `TPD_MASK_CCFG_LO;
				5: word_mask = `TPD_MASK_CCFG_HI;
				6: word_mask = `TPD_MASK_CDIV;
				default: word_mask = `TPD_MASK_OUTDIV;
			endcase
		end
	endfunction

	// word storage, quad words only when the common block exists
	wire [NW-1:0]             hit;
	wire [NW*`TPD_DRP_DW-1:0] words;
	genvar gi;
	generate
		for (gi = 0; gi < NW; gi = gi + 1)
		begin : g_word
			localparam PRESENT = (gi < 4) ? COMMON_ON : 1;
			reg [`TPD_DRP_DW-1:0] w_q;
			assign hit[gi] = (PRESENT != 0)
				&& (drp_addr == word_addr(gi));
			assign words[gi*`TPD_DRP_DW +: `TPD_DRP_DW] = w_q;
			always @(posedge ref_clk or negedge reset_n)
			begin
				if (!reset_n)
					w_q <= `TPD_WORD_RST;
				else if (drp_en && drp_we && hit[gi])
					w_q <= drp_di & word_mask(gi);
			end
		end
	endgenerate

	// read mux; unmapped addresses read zero
	reg [`TPD_DRP_DW-1:0] rd_d;
	integer ri;
	always @*
	begin
		rd_d = {`TPD_DRP_DW{1'b0}};
		for (ri = 0; ri < NW; ri = ri + 1)
			if (hit[ri])
				rd_d = rd_d | words[ri*`TPD_DRP_DW +: `TPD_DRP_DW];
	end

	// every access answered one cycle later
	always @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			drp_do  <= {`TPD_DRP_DW{1'b0}};
			drp_rdy <= 1'b0;
		end
		else
		begin
			drp_rdy <= drp_en;
			if (drp_en && !drp_we)
				drp_do <= rd_d;
			else
				drp_do <= {`TPD_DRP_DW{1'b0}};
		end
	end

	// field extraction
	wire [`TPD_DRP_DW-1:0] w_qlo  = words[0*`TPD_DRP_DW +: `TPD_DRP_DW];
	wire [`TPD_DRP_DW-1:0] w_qhi  = words[1*`TPD_DRP_DW +: `TPD_DRP_DW];
	wire [`TPD_DRP_DW-1:0] w_qfb  = words[2*`TPD_DRP_DW +: `TPD_DRP_DW];
	wire [`TPD_DRP_DW-1:0] w_qrat = words[3*`TPD_DRP_DW +: `TPD_DRP_DW];
	wire [`TPD_DRP_DW-1:0] w_cdiv = words[6*`TPD_DRP_DW +: `TPD_DRP_DW];
	wire [`TPD_DRP_DW-1:0] w_out  = words[7*`TPD_DRP_DW +: `TPD_DRP_DW];

	wire [4:0] qref_code = w_qhi[`TPD_QREF_MSB:`TPD_QREF_LSB];
	wire [9:0] qfb_val   = w_qfb[`TPD_QFB_MSB:`TPD_QFB_LSB];
	wire       qratio    = w_qrat[`TPD_QRATIO_BIT];
	wire [4:0] cref_code = w_cdiv[`TPD_CREF_MSB:`TPD_CREF_LSB];
	wire       cpre_code = w_cdiv[`TPD_CPRE_BIT];
	wire [6:0] cfb_code  = w_cdiv[`TPD_CFB_MSB:`TPD_CFB_LSB];
	wire [2:0] rx_code   = w_out[`TPD_RXOUT_MSB:`TPD_RXOUT_LSB];

	// code to divide factor; zero marks an unknown code
	reg [2:0] qref_div_d;
	reg [1:0] cref_div_d;
	reg [2:0] cpre_d;
	reg [2:0] cfb_div_d;
	reg [4:0] rx_div_d;
	reg       qfb_ok_d;

	always @*
	begin
		case (qref_code)
			5'h10: qref_div_d = 3'h1;
			5'h00: qref_div_d = 3'h2;
			5'h01: qref_div_d = 3'h3;
			5'h02: qref_div_d = 3'h4;
			default: qref_div_d = 3'h0;
		endcase
		case (cref_code)
			5'h10: cref_div_d = 2'h1;
			5'h00: cref_div_d = 2'h2;
			default: cref_div_d = 2'h0;
		endcase
		cpre_d = cpre_code ? 3'h5 : 3'h4;
		case (cfb_code)
			7'h10: cfb_div_d = 3'h1;
			7'h00: cfb_div_d = 3'h2;
			7'h01: cfb_div_d = 3'h3;
			7'h02: cfb_div_d = 3'h4;
			7'h03: cfb_div_d = 3'h5;
			default: cfb_div_d = 3'h0;
		endcase
		case (rx_code)
			3'h0: rx_div_d = 5'h01;
			3'h1: rx_div_d = 5'h02;
			3'h2: rx_div_d = 5'h04;
			3'h3: rx_div_d = 5'h08;
			3'h4: rx_div_d = 5'h10;
			default: rx_div_d = 5'h00;
		endcase
		case (qfb_val)
			10'h010, 10'h014, 10'h020, 10'h028,
			10'h040, 10'h042, 10'h050, 10'h064: qfb_ok_d = 1'b1;
			default: qfb_ok_d = 1'b0;
		endcase
	end

	// error flags, quad checks only with the common block built
	wire ratio_exp = (qfb_val != `TPD_QFB_NO_RATIO);
	wire [5:0] err_d;
	assign err_d[0] = COMMON_ON && (qref_div_d == 3'h0);
	assign err_d[1] = COMMON_ON && !qfb_ok_d;
	assign err_d[2] = COMMON_ON && (qratio != ratio_exp);
	assign err_d[3] = (cref_div_d == 2'h0);
	assign err_d[4] = (cfb_div_d == 3'h0);
	assign err_d[5] = (rx_div_d == 5'h00);

	// receive line rate = fref * num / den, core clock a fortieth of it
	wire [7:0]  qden  = {5'h00, qref_div_d} * {3'h0, rx_div_d};
	wire [7:0]  cden  = {6'h00, cref_div_d} * {3'h0, rx_div_d};
	wire [7:0]  cn12  = {5'h00, cpre_d} * {5'h00, cfb_div_d};
	wire [9:0]  cnum  = {1'b0, cn12, 1'b0};
	wire [7:0]  den_d = (RX_QUAD_SEL != 0) ? qden : cden;
	wire [9:0]  num_d = (RX_QUAD_SEL != 0) ? qfb_val : cnum;
	wire [11:0] core_d = {4'h0, den_d} * `TPD_CORE_RATIO;

	always @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			quad_band_lower_q <= 1'b0;
			quad_ref_div_q    <= 3'h0;
			quad_fb_div_q     <= 10'h000;
			quad_ratio_sel_q  <= 1'b0;
			chan_ref_div_q    <= 2'h0;
			chan_prescale_q   <= 3'h0;
			chan_fb_div_q     <= 3'h0;
			rx_out_div_q      <= 5'h00;
			rx_line_num_q     <= 10'h000;
			rx_line_den_q     <= 8'h00;
			rx_core_den_q     <= 12'h000;
			cfg_error_q       <= 6'h00;
		end
		else
		begin
			quad_band_lower_q <= w_qlo[`TPD_BAND_BIT];
			quad_ref_div_q    <= qref_div_d;
			quad_fb_div_q     <= qfb_val;
			quad_ratio_sel_q  <= qratio;
			chan_ref_div_q    <= cref_div_d;
			chan_prescale_q   <= cpre_d;
			chan_fb_div_q     <= cfb_div_d;
			rx_out_div_q      <= rx_div_d;
			rx_line_num_q     <= num_d;
			rx_line_den_q     <= den_d;
			rx_core_den_q     <= core_d;
			cfg_error_q       <= err_d;
		end
	end

	// build options seen as static outputs
	always @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			quad_refclk_en_q <= 1'b0;
			chan_refclk_en_q <= 1'b0;
			debug_full_q     <= 1'b0;
			debug_trim_q     <= 1'b0;
			common_present_q <= 1'b0;
		end
		else
		begin
			quad_refclk_en_q <= (MGMT_ON && QUAD_USED) || QUAD_USED;
			chan_refclk_en_q <= (MGMT_ON && QUAD_USED)
				|| (TX_QUAD_SEL == 0) || (RX_QUAD_SEL == 0);
			debug_full_q     <= (XCVR_DEBUG != 0) && !MGMT_ON;
			debug_trim_q     <= (XCVR_DEBUG != 0) && MGMT_ON;
			common_present_q <= COMMON_ON;
		end
	end

	// reset machine on the reconfiguration clock
	tpd_reset_seq #(
		.CYCLES (RST_CYCLES),
		.CNT_W  (16)
	) u_rst_seq (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.restart (seq_restart),
		.done_q  (reset_done_q)
	);

endmodule // tpd_config

`default_nettype wire

// File: test/tpd_config_asserts.sv
// tpd_config_asserts.sv: port-level checker of tpd_config.
// assumes one ref_clk domain and asynchronous active-low reset_n.
`timescale 1ns/1ps
`default_nettype none

module tpd_config_asserts #(
	parameter integer AXI_MGMT_EN = 1,
	parameter integer SUB_CORE    = 0,
	parameter integer TX_QUAD_SEL = 0,
	parameter integer RX_QUAD_SEL = 0
) (
	// clock and reset
	input wire logic        ref_clk,
	input wire logic        reset_n,
	// reconfiguration port
	input wire logic [8:0]  drp_addr,
	input wire logic [15:0] drp_di,
	input wire logic        drp_en,
	input wire logic        drp_we,
	input wire logic [15:0] drp_do,
	input wire logic        drp_rdy,
	// sequencing and decode
	input wire logic        seq_restart,
	input wire logic        reset_done_q,
	input wire logic        quad_band_lower_q,
	input wire logic [2:0]  quad_ref_div_q,
	input wire logic [2:0]  chan_prescale_q,
	input wire logic [4:0]  rx_out_div_q,
	input wire logic        quad_refclk_en_q,
	input wire logic        chan_refclk_en_q,
	input wire logic        common_present_q
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	a_rdy_follows_en: assert property (drp_en |=> drp_rdy)
		else $error("answer missing after access");
	a_rdy_no_en: assert property (!drp_en |=> !drp_rdy)
		else $error("answer without access");
	a_do_idle_zero: assert property (!drp_rdy |-> drp_do == 16'h0000)
		else $error("read data not zero outside answer");
	a_band_select: assert property (common_present_q && drp_en
		&& drp_we && drp_addr == 9'h032
		|-> ##2 quad_band_lower_q == $past(drp_di[6], 2))
		else $error("band select does not follow bit 6");
	a_qref_decode: assert property (common_present_q && drp_en
		&& drp_we && drp_addr == 9'h033 && drp_di[15:11] == 5'h10
		|-> ##2 quad_ref_div_q == 3'h1)
		else $error("quad reference code 16 not divide one");
	a_prescale_sel: assert property (drp_en && drp_we
		&& drp_addr == 9'h05e
		|-> ##2 chan_prescale_q == ($past(drp_di[7], 2) ? 3'h5 : 3'h4))
		else $error("channel prescale wrong");
	a_rxout_decode: assert property (drp_en && drp_we
		&& drp_addr == 9'h088
		|-> ##2 rx_out_div_q == (($past(drp_di[2:0], 2) < 3'h5)
		? (5'h01 << $past(drp_di[2:0], 2)) : 5'h00))
		else $error("receive output divide wrong");
	a_refclk_both: assert property ((AXI_MGMT_EN != 0)
		&& (SUB_CORE == 0) && ((TX_QUAD_SEL | RX_QUAD_SEL) != 0)
		&& $past(reset_n) |-> quad_refclk_en_q && chan_refclk_en_q)
		else $error("reference clock enables not both set");
	a_restart_seq: assert property (seq_restart && reset_done_q
		|=> !reset_done_q ##[1:200] reset_done_q)
		else $error("reset sequence did not run");
	a_quad_hidden: assert property (!common_present_q && drp_en
		&& !drp_we && drp_addr == 9'h032 |=> drp_do == 16'h0000)
		else $error("quad word readable without common block");
endmodule // tpd_config_asserts

bind tpd_config tpd_config_asserts #(.AXI_MGMT_EN(AXI_MGMT_EN),
	.SUB_CORE(SUB_CORE),
	.TX_QUAD_SEL(TX_QUAD_SEL), .RX_QUAD_SEL(RX_QUAD_SEL)) u_chk (
	.ref_clk, .reset_n, .drp_addr, .drp_di, .drp_en, .drp_we, .drp_do,
	.drp_rdy, .seq_restart, .reset_done_q, .quad_band_lower_q,
	.quad_ref_div_q, .chan_prescale_q, .rx_out_div_q, .quad_refclk_en_q,
	.chan_refclk_en_q, .common_present_q);

`default_nettype wire

// File: test/tpd_drp_master.sv
// tpd_drp_master.sv: management master on the reconfiguration port.
// assumes one access at a time, driven at falling edges of ref_clk.
`timescale 1ns/1ps
`default_nettype none

module tpd_drp_master (
	// clock
	input  wire logic        ref_clk,
	// answer
	input  wire logic        drp_rdy,
	input  wire logic [15:0] drp_do,
	// request
	output logic [8:0]       drp_addr,
	output logic [15:0]      drp_di,
	output logic             drp_en,
	output logic             drp_we
);
	logic [15:0] rd_q;

	initial
	begin
		drp_addr = 9'h000;
		drp_di = 16'h0000;
		drp_en = 1'b0;
		drp_we = 1'b0;
	end

	task automatic xfer(input logic we, input logic [8:0] a,
		input logic [15:0] d);
		int n;
		@(negedge ref_clk);
		drp_en = 1'b1;
		drp_we = we;
		drp_addr = a;
		drp_di = d;
		@(negedge ref_clk);
		drp_en = 1'b0;
		n = 0;
		while (drp_rdy !== 1'b1 && n < 8)
		begin
			@(negedge ref_clk);
			n++;
		end
		rd_q = drp_do;
		// released lines show no stale value
		drp_addr = ~a;
		drp_di = ~d;
	endtask
endmodule // tpd_drp_master

`default_nettype wire

// File: test/tb_transceiver_pll_divider_config.sv
// tb_transceiver_pll_divider_config.sv: self-checking bench of tpd_config.
// assumes tpd_drp_master and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
	err_count++; $display("unexpected %s exp %h got %h", n, e, g); end end

module tb_transceiver_pll_divider_config;
	logic        ref_clk = 1'b0, reset_n = 1'b0, seq_restart = 1'b0;
	logic [8:0]  drp_addr;
	logic [15:0] drp_di, drp_do;
	logic        drp_en, drp_we, drp_rdy, reset_done_q, quad_band_lower_q;
	logic        quad_ratio_sel_q, quad_refclk_en_q, chan_refclk_en_q;
	logic        debug_full_q, debug_trim_q, common_present_q;
	logic [2:0]  quad_ref_div_q, chan_prescale_q, chan_fb_div_q;
	logic [9:0]  quad_fb_div_q, rx_line_num_q;
	logic [1:0]  chan_ref_div_q;
	logic [4:0]  rx_out_div_q;
	logic [7:0]  rx_line_den_q;
	logic [11:0] rx_core_den_q;
	logic [5:0]  cfg_error_q;
	logic [16:0] exp_q[$];
	logic [16:0] e;
	int          err_count = 0, cmp_count = 0, cyc = 0;
	logic [8:0]  at [8] = '{9'h032, 9'h033, 9'h036, 9'h037, 9'h05c,
		9'h05d, 9'h05e, 9'h088};
	logic [15:0] mt [8] = '{16'hffff, 16'hffff, 16'h03ff, 16'h0040,
		16'hff00, 16'hffff, 16'h1fff, 16'h0007};
	logic [4:0]  qc [4] = '{5'h10, 5'h00, 5'h01, 5'h02};
	int          nt [8] = '{16, 20, 32, 40, 64, 66, 80, 100};

	always #4 ref_clk = ~ref_clk;

	tpd_drp_master m (.ref_clk, .drp_rdy, .drp_do, .drp_addr, .drp_di,
		.drp_en, .drp_we);

	tpd_config #(.RX_QUAD_SEL(1), .RST_CYCLES(4)) dut (.ref_clk, .reset_n,
		.drp_addr, .drp_di, .drp_en, .drp_we, .drp_do, .drp_rdy,
		.seq_restart, .reset_done_q, .quad_band_lower_q, .quad_ref_div_q,
		.quad_fb_div_q, .quad_ratio_sel_q, .chan_ref_div_q,
		.chan_prescale_q, .chan_fb_div_q, .rx_out_div_q, .rx_line_num_q,
		.rx_line_den_q, .rx_core_den_q, .cfg_error_q, .quad_refclk_en_q,
		.chan_refclk_en_q, .debug_full_q, .debug_trim_q, .common_present_q);

	// sub-unit build: management forced off, full debug list
	wire [4:0]   opt2;
	tpd_config #(.SUB_CORE(1), .XCVR_DEBUG(1), .RX_QUAD_SEL(1),
		.RST_CYCLES(4)) dut2 (.ref_clk, .reset_n, .drp_addr, .drp_di,
		.drp_en, .drp_we, .drp_do(), .drp_rdy(), .seq_restart,
		.reset_done_q(), .quad_band_lower_q(), .quad_ref_div_q(),
		.quad_fb_div_q(), .quad_ratio_sel_q(), .chan_ref_div_q(),
		.chan_prescale_q(), .chan_fb_div_q(), .rx_out_div_q(),
		.rx_line_num_q(), .rx_line_den_q(), .rx_core_den_q(),
		.cfg_error_q(), .quad_refclk_en_q(opt2[3]),
		.chan_refclk_en_q(opt2[2]), .debug_full_q(opt2[1]),
		.debug_trim_q(opt2[0]), .common_present_q(opt2[4]));

	task automatic print_verdict;
		if (err_count == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// bit 16 of a note asks for a read data compare
	task automatic acc(input logic we, input logic [8:0] a,
		input logic [15:0] d, input logic [16:0] x);
		exp_q.push_back(x);
		m.xfer(we, a, d);
		@(negedge ref_clk);
	endtask

	task automatic rmw(input logic [8:0] a, input logic [15:0] k,
		input logic [15:0] d);
		acc(1'b0, a, 16'h0000, 17'h00000);
		acc(1'b1, a, (m.rd_q & ~k) | (d & k), 17'h00000);
	endtask

	always @(negedge ref_clk)
		if (drp_rdy === 1'b1)
		begin
			e = (exp_q.size() > 0) ? exp_q.pop_front() : 17'h1dead;
			if (e[16])
				`CHK("drp_do", e[15:0], drp_do)
		end

	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			err_count++;
			print_verdict;
		end
	end

	initial
	begin
		int n;
		logic [15:0] r;
		void'($urandom(41804));
		repeat (4) @(negedge ref_clk);
		reset_n = 1'b1;
		for (int i = 0; i < 8; i++)
			acc(1'b0, at[i], 16'h0000, 17'h10000);
		`CHK("decode0", 7'h06, {rx_out_div_q, chan_ref_div_q})
		`CHK("options", 5'h1c, {common_present_q, quad_refclk_en_q,
			chan_refclk_en_q, debug_full_q, debug_trim_q})
		`CHK("options2", 5'h0e, opt2)
		for (int i = 0; i < 8; i++)
		begin
			r = 16'($urandom);
			acc(1'b1, at[i], r, 17'h00000);
			acc(1'b0, at[i], 16'h0000, {1'b1, r & mt[i]});
		end
		acc(1'b1, 9'h040, 16'hffff, 17'h00000);
		acc(1'b0, 9'h040, 16'h0000, 17'h10000);
		for (int i = 0; i < 5; i++)
		begin
			rmw(9'h033, 16'hf800, {(i < 4) ? qc[i] : 5'h03, 11'h000});
			`CHK("qref", {(i < 4) ? 3'(i + 1) : 3'h0, i == 4},
				{quad_ref_div_q, cfg_error_q[0]})
		end
		for (int i = 0; i < 5; i++)
		begin
			acc(1'b1, 9'h05e, {3'h0, i[0] ? 5'h00 : 5'h10, i[0],
				(i > 0) ? 7'(i - 1) : 7'h10}, 17'h00000);
			`CHK("chan", {2'(1 + i[0]), 3'(4 + i[0]), 3'(i + 1)},
				{chan_ref_div_q, chan_prescale_q, chan_fb_div_q})
		end
		for (int i = 0; i < 6; i++)
		begin
			acc(1'b1, 9'h088, 16'(i), 17'h00000);
			`CHK("rx_out", {(i < 5) ? 5'(1 << i) : 5'h00, i == 5},
				{rx_out_div_q, cfg_error_q[5]})
		end
		for (int i = 0; i < 3; i++)
		begin
			rmw(9'h032, 16'h0040, {9'h000, i[0], 6'h00});
			`CHK("band", i[0], quad_band_lower_q)
		end
		for (int i = 0; i < 8; i++)
		begin
			acc(1'b1, 9'h036, 16'(nt[i]), 17'h00000);
			acc(1'b1, 9'h037, (nt[i] == 66) ? 16'h0 : 16'h0040, 17'h0);
			`CHK("fb_err", 2'h0, cfg_error_q[2:1])
		end
		acc(1'b1, 9'h036, 16'd66, 17'h00000);
		`CHK("ratio_err", 1'b1, cfg_error_q[2])
		acc(1'b1, 9'h036, 16'd17, 17'h00000);
		`CHK("fb_bad", 1'b1, cfg_error_q[1])
		acc(1'b1, 9'h036, 16'd40, 17'h00000);
		rmw(9'h033, 16'hf800, 16'h8000);
		acc(1'b1, 9'h088, 16'h0001, 17'h00000);
		`CHK("rate", {10'd40, 8'd2}, {rx_line_num_q, rx_line_den_q})
		`CHK("core", 12'd80, rx_core_den_q)
		seq_restart = 1'b1;
		@(negedge ref_clk);
		seq_restart = 1'b0;
		`CHK("done_low", 1'b0, reset_done_q)
		n = 0;
		while (reset_done_q !== 1'b1 && n < 50)
		begin
			@(negedge ref_clk);
			n++;
		end
		`CHK("done_cycles", 8'd4, 8'(n))
		`CHK("notes_left", 0, exp_q.size())
		print_verdict;
	end
endmodule // tb_transceiver_pll_divider_config

`default_nettype wire
